//--- verilog/sadc_top.v
// Operation
// R1: Ten-bit result read as two bus reads
// R2: First read gives the eight upper bits
// R3: Second read gives the two lower bits
// R4: Power-down mode: sleep when conversion ends
// R5: Power-down mode: wake on new start
// R6: Fully powered within one microsecond
// R7: High-speed mode stays powered between conversions
// R8: Result ready within 2.3 us of start (power-down mode: 1 us wake first, about 3.3 us)
// R9: Start falling edge raises busy within 30 ns
// R10: Data valid after read low, released after
// R11: Host leaves gap between the two reads
// R12: Host waits before next start strobe
// R13: Busy held for whole conversion, then dropped
// R14: Drive bus only with select and read low
`include "sadc_defs.vh"

module sadc_top (
	input  wire                   clk_in,
	input  wire                   rst_n_in,
	input  wire                   conversion_start_n_in,
	input  wire                   cs_n_in,
	input  wire                   rd_n_in,
	input  wire                   power_down_mode_in,
	input  wire                   comparator_in,
	output reg  [`SADC_BUS_W-1:0] data_out,
	output reg                    data_oe_out,
	output reg                    busy_out,
	output reg                    analog_power_on_out,
	output reg                    track_hold_out,
	output wire [`SADC_RES_W-1:0] dac_code_out
);

	// ****************************************
	// States and constants
	// ****************************************
	localparam ST_IDLE = 2'b00;
	localparam ST_WAKE = 2'b01;
	localparam ST_CONV = 2'b10;
	localparam integer PWRUP_LAST_I = `SADC_PWRUP_CYC - 1;
	localparam [7:0]   PWRUP_LAST   = PWRUP_LAST_I[7:0];

	// ****************************************
	// Pin synchronisers
	// ****************************************
	reg        start_s1_ff;
	reg        start_s2_ff;
	reg        start_d_ff;
	reg        cs_s1_ff;
	reg        cs_s2_ff;
	reg        rd_s1_ff;
	reg        rd_s2_ff;
	reg        pd_s1_ff;
	reg        pd_s2_ff;
	reg        cmp_s1_ff;
	reg        cmp_s2_ff;

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			start_s1_ff <= 1'b1;
			start_s2_ff <= 1'b1;
			start_d_ff  <= 1'b1;
			cs_s1_ff    <= 1'b1;
			cs_s2_ff    <= 1'b1;
			rd_s1_ff    <= 1'b1;
			rd_s2_ff    <= 1'b1;
			pd_s1_ff    <= 1'b0;
			pd_s2_ff    <= 1'b0;
			cmp_s1_ff   <= 1'b0;
			cmp_s2_ff   <= 1'b0;
		end else begin
			start_s1_ff <= conversion_start_n_in;
			start_s2_ff <= start_s1_ff;
			start_d_ff  <= start_s2_ff;
			cs_s1_ff    <= cs_n_in;
			cs_s2_ff    <= cs_s1_ff;
			rd_s1_ff    <= rd_n_in;
			rd_s2_ff    <= rd_s1_ff;
			pd_s1_ff    <= power_down_mode_in;
			pd_s2_ff    <= pd_s1_ff;
			cmp_s1_ff   <= comparator_in;
			cmp_s2_ff   <= cmp_s1_ff;
		end
	end

	wire start_fall;
	wire read_sel;

	assign start_fall = start_d_ff && !start_s2_ff;
	assign read_sel   = !cs_s2_ff && !rd_s2_ff;

	// ****************************************
	// Conversion engine and result buffer
	// ****************************************
	reg                    sar_start_ff;
	wire [`SADC_RES_W-1:0] sar_result;
	wire                   sar_done;
	wire                   fifo_in_ready;
	wire                   fifo_out_valid;
	wire [`SADC_RES_W-1:0] fifo_out_data;
	wire                   fifo_pop;

	sadc_sar u_sar (
		.clk_in       (clk_in),
		.rst_n_in     (rst_n_in),
		.start_in     (sar_start_ff),
		.cmp_in       (cmp_s2_ff),
		.dac_code_out (dac_code_out),
		.result_out   (sar_result),
		.done_out     (sar_done)
	);

	// Full buffer refuses starts rather than losing results
	sadc_fifo #(
		.W     (`SADC_RES_W),
		.DEPTH (`SADC_FIFO_DEPTH),
		.AW    (`SADC_FIFO_AW)
	) u_fifo (
		.clk_in        (clk_in),
		.rst_n_in      (rst_n_in),
		.in_valid_in   (sar_done),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (sar_result),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (fifo_pop),
		.out_data_out  (fifo_out_data)
	);

	// ****************************************
	// Conversion control
	// ****************************************
	reg [1:0] state_ff;
	reg [7:0] pwr_cnt_ff;

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_ff            <= ST_IDLE;
			pwr_cnt_ff          <= `SADC_CNT_RST;
			sar_start_ff        <= 1'b0;
			busy_out            <= 1'b0;
			analog_power_on_out <= 1'b0;
			track_hold_out      <= 1'b0;
		end else begin
			sar_start_ff <= 1'b0;
			case (state_ff)
			ST_IDLE: begin
				if (!pd_s2_ff) begin
					analog_power_on_out <= 1'b1; // [R7]
				end
				if (start_fall && fifo_in_ready) begin
					busy_out       <= 1'b1; // [R9] [R13]
					track_hold_out <= 1'b1;
					if (analog_power_on_out && !pd_s2_ff) begin
						sar_start_ff <= 1'b1; // [R7]
						state_ff     <= ST_CONV;
					end else begin
						analog_power_on_out <= 1'b1; // [R5]
						pwr_cnt_ff          <= `SADC_CNT_RST;
						state_ff            <= ST_WAKE;
					end
				end
			end
			ST_WAKE: begin
				// Settle time counted from the falling edge, ahead of the rising one
				if (pwr_cnt_ff == PWRUP_LAST) begin
					sar_start_ff <= 1'b1; // [R6]
					state_ff     <= ST_CONV;
				end else begin
					pwr_cnt_ff <= pwr_cnt_ff + 8'h01;
				end
			end
			ST_CONV: begin
				if (sar_done) begin
					busy_out       <= 1'b0; // [R8] [R13]
					track_hold_out <= 1'b0;
					if (pd_s2_ff) begin
						analog_power_on_out <= 1'b0; // [R4]
					end
					state_ff <= ST_IDLE;
				end
			end
			default: begin
				state_ff <= ST_IDLE;
			end
			endcase
		end
	end

	// ****************************************
	// Two-read parallel readout
	// ****************************************
	reg [`SADC_RES_W-1:0] word_ff;
	reg                   word_valid_ff;
	reg                   lsb_phase_ff;
	reg                   sel_d_ff;

	// Only refill between reads so a byte never changes under the host
	assign fifo_pop = !word_valid_ff && fifo_out_valid && !read_sel && !sel_d_ff;

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			word_ff       <= `SADC_CODE_RST;
			word_valid_ff <= 1'b0;
			lsb_phase_ff  <= 1'b0;
			sel_d_ff      <= 1'b0;
			data_out      <= `SADC_DATA_RST;
			data_oe_out   <= 1'b0;
		end else begin
			sel_d_ff    <= read_sel;
			data_oe_out <= read_sel; // [R10] [R14]
			if (fifo_pop) begin
				word_ff       <= fifo_out_data;
				word_valid_ff <= 1'b1;
				lsb_phase_ff  <= 1'b0;
			end else if (sel_d_ff && !read_sel) begin
				// A read ends on the rise of select or strobe
				if (lsb_phase_ff) begin
					lsb_phase_ff  <= 1'b0; // [R1]
					word_valid_ff <= 1'b0;
				end else begin
					lsb_phase_ff <= 1'b1; // [R11]
				end
			end
			if (lsb_phase_ff) begin
				data_out <= {`SADC_LSB_PAD, word_ff[`SADC_LSB_HI:`SADC_LSB_LO]}; // [R3]
			end else begin
				data_out <= word_ff[`SADC_MSB_HI:`SADC_MSB_LO]; // [R2]
			end
		end
	end

endmodule // sadc_top

//--- verilog/sadc_defs.vh
`ifndef SADC_DEFS_VH
`define SADC_DEFS_VH

// ****************************************
// Widths and depths
// ****************************************
`define SADC_RES_W          10
`define SADC_BUS_W          8
`define SADC_FIFO_DEPTH     16
`define SADC_FIFO_AW        4

// ****************************************
// Field positions of the result word
// ****************************************
`define SADC_MSB_HI         9
`define SADC_MSB_LO         2
`define SADC_LSB_HI         1
`define SADC_LSB_LO         0

// ****************************************
// Reset, start and padding values
// ****************************************
`define SADC_DATA_RST       8'h00
`define SADC_CODE_RST       10'h000
`define SADC_TRIAL_MSB      10'h200
`define SADC_LSB_PAD        6'h00
`define SADC_CNT_RST        8'h00

// ****************************************
// Timing in ns, and counts at the clock rate
// ****************************************
`define SADC_CLK_MHZ        100
`define SADC_T_CONV_NS      2300
`define SADC_T_PWRUP_NS     1000
`define SADC_T_BUSY_NS      30
`define SADC_CONV_CYC       ((`SADC_T_CONV_NS * `SADC_CLK_MHZ) / 1000)
`define SADC_PWRUP_CYC      ((`SADC_T_PWRUP_NS * `SADC_CLK_MHZ) / 1000)
`define SADC_BUSY_CYC       ((`SADC_T_BUSY_NS * `SADC_CLK_MHZ) / 1000)
`define SADC_STEP_CYC       (`SADC_CONV_CYC / (`SADC_RES_W + 1))

`endif

//--- verilog/sadc_fifo.v
module sadc_fifo #(
	parameter W     = 10,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire          clk_in,
	input  wire          rst_n_in,
	input  wire          in_valid_in,
	output wire          in_ready_out,
	input  wire [W-1:0]  in_data_in,
	output wire          out_valid_out,
	input  wire          out_ready_in,
	output wire [W-1:0]  out_data_out
);

	// ****************************************
	// Storage and pointers
	// ****************************************
	reg [W-1:0] mem [0:DEPTH-1];
	reg [AW:0]  wr_ptr_ff;
	reg [AW:0]  rd_ptr_ff;
	wire        full;
	wire        empty;
	wire        push;
	wire        pop;

	// Extra pointer bit tells full from empty
	assign empty         = (wr_ptr_ff == rd_ptr_ff);
	assign full          = (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]) &&
	                       (wr_ptr_ff[AW] != rd_ptr_ff[AW]);
	assign in_ready_out  = !full;
	assign out_valid_out = !empty;
	assign out_data_out  = mem[rd_ptr_ff[AW-1:0]];
	assign push          = in_valid_in && !full;
	assign pop           = out_ready_in && !empty;

	always @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr_ff[AW-1:0]] <= in_data_in;
		end
	end

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_ff <= {(AW+1){1'b0}};
			rd_ptr_ff <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
		end
	end

endmodule // sadc_fifo

//--- verilog/sadc_sar.v
`include "sadc_defs.vh"

module sadc_sar (
	input  wire                   clk_in,
	input  wire                   rst_n_in,
	input  wire                   start_in,
	input  wire                   cmp_in,
	output reg  [`SADC_RES_W-1:0] dac_code_out,
	output reg  [`SADC_RES_W-1:0] result_out,
	output reg                    done_out
);

	localparam ST_IDLE = 1'b0;
	localparam ST_STEP = 1'b1;
	localparam integer STEP_LAST_I = `SADC_STEP_CYC - 1;
	localparam [7:0]   STEP_LAST   = STEP_LAST_I[7:0];

	reg       state_ff;
	reg [3:0] bit_ff;
	reg [7:0] cnt_ff;

	function [`SADC_RES_W-1:0] bit_mask;
		input [3:0] b;
		begin
			bit_mask = {{(`SADC_RES_W-1){1'b0}}, 1'b1} << b;
		end
	endfunction

	// ****************************************
	// Binary search, one bit per step
	// ****************************************
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_ff     <= ST_IDLE;
			bit_ff       <= 4'h0;
			cnt_ff       <= `SADC_CNT_RST;
			dac_code_out <= `SADC_CODE_RST;
			result_out   <= `SADC_CODE_RST;
			done_out     <= 1'b0;
		end else begin
			done_out <= 1'b0;
			case (state_ff)
			ST_IDLE: begin
				if (start_in) begin
					dac_code_out <= `SADC_TRIAL_MSB;
					bit_ff       <= 4'h9;
					cnt_ff       <= `SADC_CNT_RST;
					state_ff     <= ST_STEP;
				end
			end
			ST_STEP: begin
				if (cnt_ff != STEP_LAST) begin
					cnt_ff <= cnt_ff + 8'h01;
				end else begin
					cnt_ff <= `SADC_CNT_RST;
					// Step long enough to cover comparator sync delay
					if (bit_ff == 4'h0) begin
						result_out <= cmp_in ? dac_code_out
						                     : (dac_code_out & ~bit_mask(bit_ff));
						done_out   <= 1'b1;
						state_ff   <= ST_IDLE;
					end else begin
						dac_code_out <= (cmp_in ? dac_code_out
						                        : (dac_code_out & ~bit_mask(bit_ff)))
						                | bit_mask(bit_ff - 4'h1);
						bit_ff       <= bit_ff - 4'h1;
					end
				end
			end
			default: begin
				state_ff <= ST_IDLE;
			end
			endcase
		end
	end

endmodule // sadc_sar

//--- tb/sadc_monitor.sv
module sadc_monitor (
	input wire       clk_in,
	input wire       rst_n_in,
	input wire       conversion_start_n_in,
	input wire       cs_n_in,
	input wire       rd_n_in,
	input wire       power_down_mode_in,
	input wire [7:0] data_out,
	input wire       data_oe_out,
	input wire       busy_out,
	input wire       analog_power_on_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************
	// Busy length
	// ****************
	reg [9:0] busy_cnt_ff;
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			busy_cnt_ff <= 10'h000;
		else
			busy_cnt_ff <= busy_out ? busy_cnt_ff + 10'h001 : 10'h000;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// ****************
	// Properties
	// ****************
	property p_busy_rise;
		$rose(busy_out) |-> !$past(conversion_start_n_in, 2);
	endproperty
	property p_busy_hold;
		$fell(busy_out) |-> busy_cnt_ff >= 10'h0c8;
	endproperty
	property p_conv_time;
		$fell(busy_out) && !power_down_mode_in |-> busy_cnt_ff <= 10'h0e6;
	endproperty
	property p_pd_sleep;
		$fell(busy_out) && power_down_mode_in |-> ##[0:2] !analog_power_on_out;
	endproperty
	property p_pd_wake;
		$fell(conversion_start_n_in) && power_down_mode_in && !busy_out
			|-> ##[1:105] analog_power_on_out;
	endproperty
	property p_hs_on;
		(!power_down_mode_in) [*5] |-> analog_power_on_out;
	endproperty
	property p_bus_oe;
		data_oe_out == $past(!cs_n_in && !rd_n_in, 3);
	endproperty
	property p_data_hold;
		data_oe_out && $past(data_oe_out) |-> $stable(data_out);
	endproperty
	a_busy_rise: assert property (p_busy_rise)
		else $error("busy rose without a start strobe");
	a_busy_hold: assert property (p_busy_hold)
		else $error("busy dropped too early");
	a_conv_time: assert property (p_conv_time)
		else $error("conversion too long");
	a_pd_sleep: assert property (p_pd_sleep)
		else $error("no power down after conversion");
	a_pd_wake: assert property (p_pd_wake)
		else $error("no wake after start");
	a_hs_on: assert property (p_hs_on)
		else $error("power off in high speed mode");
	a_bus_oe: assert property (p_bus_oe)
		else $error("bus drive not tied to select and read");
	a_data_hold: assert property (p_data_hold)
		else $error("data moved during read");
	c_pd_conv: cover property ($fell(busy_out) && power_down_mode_in);
	c_hs_conv: cover property ($fell(busy_out) && !power_down_mode_in);
	c_read: cover property ($rose(data_oe_out));
endmodule // sadc_monitor

bind sadc_top sadc_monitor u_mon (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .conversion_start_n_in(conversion_start_n_in),
	.cs_n_in(cs_n_in), .rd_n_in(rd_n_in), .power_down_mode_in(power_down_mode_in),
	.data_out(data_out), .data_oe_out(data_oe_out), .busy_out(busy_out),
	.analog_power_on_out(analog_power_on_out)
);

//--- tb/sadc_host.sv
module sadc_host (
	input  wire       clk_in,
	input  wire [7:0] bus_in,
	input  wire       oe_in,
	output reg        start_n_out,
	output reg        cs_n_out,
	output reg        rd_n_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		start_n_out = 1'b1;
		cs_n_out = 1'b1;
		rd_n_out = 1'b1;
	end
	// ****************
	// Start strobe, 30 ns low
	// ****************
	task conv;
		begin
			repeat (6) @(posedge clk_in);
			#1 start_n_out = 1'b0;
			repeat (3) @(posedge clk_in);
			#1 start_n_out = 1'b1;
		end
	endtask
	// ****************
	// One bus read, held until drive seen
	// ****************
	task rd(output [7:0] v);
		integer n;
		begin
			@(posedge clk_in);
			#1 cs_n_out = 1'b0;
			rd_n_out = 1'b0;
			n = 0;
			@(posedge clk_in);
			while (oe_in !== 1'b1 && n < 10) begin
				@(posedge clk_in);
				n = n + 1;
			end
			v = bus_in;
			#1 cs_n_out = 1'b1;
			rd_n_out = 1'b1;
			n = 0;
			while (oe_in !== 1'b0 && n < 10) begin
				@(posedge clk_in);
				n = n + 1;
			end
			repeat (2) @(posedge clk_in);
		end
	endtask
	task rd_nosel(input integer n);
		begin
			@(posedge clk_in);
			#1 rd_n_out = 1'b0;
			repeat (n) @(posedge clk_in);
			#1 rd_n_out = 1'b1;
		end
	endtask
endmodule // sadc_host

//--- tb/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	reg        clk_in = 1'b0;
	reg        rst_n_in = 1'b0;
	reg        pd_mode = 1'b0;
	reg  [9:0] vin = 10'h000;
	wire       start_n, cs_n, rd_n, oe, busy, pwr, th;
	wire [7:0] data, bus;
	wire [9:0] dac;
	integer    n_fail = 0;
	integer    total_checks = 0;
	always #5 clk_in = ~clk_in;
	// Released bus must not look like the last byte
	assign bus = oe ? data : ~data;
	sadc_top dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .conversion_start_n_in(start_n),
		.cs_n_in(cs_n), .rd_n_in(rd_n), .power_down_mode_in(pd_mode),
		.comparator_in(vin >= dac), .data_out(data), .data_oe_out(oe),
		.busy_out(busy), .analog_power_on_out(pwr), .track_hold_out(th), .dac_code_out(dac)
	);
	sadc_host host (
		.clk_in(clk_in), .bus_in(bus), .oe_in(oe),
		.start_n_out(start_n), .cs_n_out(cs_n), .rd_n_out(rd_n)
	);
	// ****************
	// Helpers
	// ****************
	task chk(input logic [9:0] got, input logic [9:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task complete_run;
		begin
			$display("checks=%0d fails=%0d", total_checks, n_fail);
			if (n_fail == 0 && total_checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task do_conv(input [9:0] v, input integer lim, output reg acc);
		integer n;
		begin
			vin = v;
			host.conv;
			acc = (busy === 1'b1);
			if (acc) chk(th, 1'b1);
			n = 0;
			while (acc && busy !== 1'b0 && n < 400) begin
				@(posedge clk_in);
				n = n + 1;
			end
			if (acc) chk(n <= lim, 1'b1);
			if (acc) chk(th, 1'b0);
		end
	endtask
	task read_word(input [9:0] e);
		reg [7:0] b;
		begin
			host.rd(b);
			chk(b, e[9:2]);
			host.rd(b);
			chk(b, {6'h00, e[1:0]});
		end
	endtask
	// ****************
	// Scenarios
	// ****************
	task t_hs;
		reg acc;
		begin
			do_conv(10'h2a5, 230, acc);
			chk(acc, 1'b1);
			chk(pwr, 1'b1);
			read_word(10'h2a5);
			fork
				host.rd_nosel(6);
				begin
					repeat (5) @(posedge clk_in);
					#2 chk(oe, 1'b0);
				end
			join
		end
	endtask
	task t_pd;
		reg acc;
		begin
			pd_mode = 1'b1;
			do_conv(10'h0ff, 330, acc);
			chk(acc, 1'b1);
			repeat (3) @(posedge clk_in);
			#1 chk(pwr, 1'b0);
			read_word(10'h0ff);
			#1 pd_mode = 1'b0;
		end
	endtask
	// Fill until starts are refused, then drain in order
	task t_fifo;
		integer i;
		reg acc;
		reg [9:0] v;
		begin
			i = 0;
			acc = 1'b1;
			v = 10'h005;
			while (acc && i < 20) begin
				do_conv(v, 230, acc);
				if (acc) i = i + 1;
				v = v + 10'h03d;
			end
			chk(i >= 16 && i <= 17, 1'b1);
			v = 10'h005;
			repeat (i) begin
				read_word(v);
				v = v + 10'h03d;
			end
		end
	endtask
	initial begin
		repeat (20) @(posedge clk_in);
		#1 rst_n_in = 1'b1;
		repeat (3) @(posedge clk_in);
		t_hs;
		t_pd;
		t_fifo;
		complete_run;
	end
	initial begin
		repeat (30000) @(posedge clk_in);
		n_fail = n_fail + 1;
		complete_run;
	end
endmodule // tb_top
